//--- rtl/cfm_clock_fail_monitor.sv
// Clock fail monitor with fallback, switch-back control and register slave.
`timescale 1ns/1ns
`default_nettype none

module cfm_clock_fail_monitor
#(
  parameter int OST_COUNT = cfm_pkg::OST_COUNT,
  parameter int LF_DIV    = cfm_pkg::LF_DIV
)
(
  input  wire logic             sys_clk_i,
  input  wire logic             rst_n_i,
  input  wire logic [7:0]       avs_address_i,
  input  wire logic             avs_read_i,
  input  wire logic             avs_write_i,
  input  wire logic [31:0]      avs_writedata_i,
  output logic      [31:0]      avs_readdata_o,
  output logic                  avs_waitrequest_o,
  input  wire logic             ext_clk_i,
  input  wire logic             low_freq_internal_osc_i,
  input  wire logic             sleep_exec_i,
  output cfm_pkg::cfm_cfg_t     cur_cfg_o,
  output logic                  failsafe_o,
  output logic                  ost_running_o,
  output logic                  irq_o
);

  localparam int HALF  = LF_DIV / 2;
  localparam int DW    = $clog2(HALF);
  localparam int OW    = $clog2(OST_COUNT);
  localparam logic [DW-1:0] HALF_M1 = DW'(HALF - 1);
  localparam logic [OW-1:0] OST_M1  = OW'(OST_COUNT - 1);

  typedef enum logic {SW_IDLE, SW_OST} cfm_sw_t;

  logic              ext_d;
  logic              lf_d;
  logic [DW-1:0]     div_cnt;
  logic              samp_clk;
  logic              seen;
  logic              fail_raw;
  logic              fail_s1;
  logic              fail_sync;
  logic              mon_en;
  logic              int_en;
  logic              flag;
  cfm_pkg::cfm_cfg_t new_cfg;
  cfm_pkg::cfm_cfg_t wr_cfg;
  cfm_sw_t           state;
  logic [OW-1:0]     ost_cnt;
  logic [31:0]       next_rdata;

  logic ext_fall;
  logic lf_rise;
  logic samp_rise;
  logic samp_fall;
  logic wr;
  logic new_chg;
  logic monitored;
  logic fail_event;
  logic ost_done;

  // Inputs arrive synchronous to the system clock; keep last level.
  always_ff @(posedge sys_clk_i)
  begin
    if (!rst_n_i)
    begin
      ext_d <= 1'h0;
      lf_d  <= 1'h0;
    end
    else
    begin
      ext_d <= ext_clk_i;
      lf_d  <= low_freq_internal_osc_i;
    end
  end

  assign ext_fall  = ext_d & ~ext_clk_i;
  assign lf_rise   = ~lf_d & low_freq_internal_osc_i;
  assign samp_rise = lf_rise && (div_cnt == HALF_M1) && !samp_clk;
  assign samp_fall = lf_rise && (div_cnt == HALF_M1) && samp_clk;

  // Sample clock toggles every half of the divide count.
  always_ff @(posedge sys_clk_i)
  begin
    if (!rst_n_i)
    begin
      div_cnt  <= '0;
      samp_clk <= 1'h0;
    end
    else if (lf_rise)
    begin
      if (div_cnt == HALF_M1)
      begin
        div_cnt  <= '0;
        samp_clk <= ~samp_clk;
      end
      else
      begin
        div_cnt <= div_cnt + DW'(1);
      end
    end
  end

  // Detect latch; a fall coinciding with the clear still counts, which
  // avoids a false failure on a slow but healthy clock.
  always_ff @(posedge sys_clk_i)
  begin
    if (!rst_n_i)
      seen <= 1'h0;
    else if (ext_fall)
      seen <= 1'h1;
    else if (samp_rise)
      seen <= 1'h0;
  end

  // Judged at the falling sample edge, one half period after the clear.
  always_ff @(posedge sys_clk_i)
  begin
    if (!rst_n_i)
      fail_raw <= 1'h0;
    else if (samp_fall)
      fail_raw <= ~(seen | ext_fall);
  end

  // Two-stage synchroniser; only the second stage is used downstream.
  always_ff @(posedge sys_clk_i)
  begin
    if (!rst_n_i)
    begin
      fail_s1   <= 1'h0;
      fail_sync <= 1'h0;
    end
    else
    begin
      fail_s1   <= fail_raw;
      fail_sync <= fail_s1;
    end
  end

  // Bus decode; a write takes effect when waitrequest is seen low.
  assign wr       = avs_write_i && !avs_waitrequest_o;
  assign wr_cfg   = cfm_pkg::cfm_cfg_t'(avs_writedata_i[cfm_pkg::CFG_W-1:0]);
  assign new_chg  = wr && (avs_address_i == cfm_pkg::ADDR_NEW) &&
                    ((wr_cfg.osc != new_cfg.osc) ||
                     (wr_cfg.div != new_cfg.div));
  // All external modes, and any external target under start-up, are watched.
  assign monitored  = mon_en && (cfm_pkg::cfm_is_ext(cur_cfg_o.osc) ||
                      (state == SW_OST));
  assign fail_event = fail_sync && monitored && !failsafe_o;
  assign ost_done   = (state == SW_OST) && ext_fall && (ost_cnt == OST_M1);

  // Control bits written by software.
  always_ff @(posedge sys_clk_i)
  begin
    if (!rst_n_i)
    begin
      mon_en  <= cfm_pkg::RST_MON_EN;
      int_en  <= cfm_pkg::RST_INT_EN;
      new_cfg <= cfm_pkg::RST_CFG;
    end
    else if (wr && (avs_address_i == cfm_pkg::ADDR_CTRL))
    begin
      mon_en <= avs_writedata_i[cfm_pkg::CTRL_MON_BIT];
      int_en <= avs_writedata_i[cfm_pkg::CTRL_IE_BIT];
    end
    else if (wr && (avs_address_i == cfm_pkg::ADDR_NEW))
    begin
      new_cfg <= wr_cfg;
    end
  end

  // Source switching; a failure overrides any switch in progress.
  always_ff @(posedge sys_clk_i)
  begin
    if (!rst_n_i)
    begin
      state     <= SW_IDLE;
      ost_cnt   <= '0;
      cur_cfg_o <= cfm_pkg::RST_CFG;
    end
    else if (fail_event)
    begin
      // Only the source changes, so frequency and divider carry over.
      cur_cfg_o.osc <= cfm_pkg::OSC_HFINT;
      state         <= SW_IDLE;
    end
    else if (new_chg)
    begin
      if (cfm_pkg::cfm_is_ext(wr_cfg.osc))
      begin
        state   <= SW_OST;
        ost_cnt <= '0;
      end
      else
      begin
        state     <= SW_IDLE;
        cur_cfg_o <= wr_cfg;
      end
    end
    else
    begin
      unique case (state)
        SW_IDLE:
        begin
          ost_cnt <= '0;
        end
        SW_OST:
        begin
          // The running clock stays untouched until the count ends.
          if (ost_done)
          begin
            cur_cfg_o <= new_cfg;
            state     <= SW_IDLE;
          end
          else if (ext_fall)
          begin
            ost_cnt <= ost_cnt + OW'(1);
          end
        end
      endcase
    end
  end

  // Fail-safe condition; a new failure wins over any clear.
  always_ff @(posedge sys_clk_i)
  begin
    if (!rst_n_i)
      failsafe_o <= 1'h0;
    else if (fail_event)
      failsafe_o <= 1'h1;
    else if (new_chg || sleep_exec_i)
      failsafe_o <= 1'h0;
    else if (ost_done)
      failsafe_o <= 1'h0;
  end

  // Fail flag is write-one-to-clear, and setting wins over clearing.
  always_ff @(posedge sys_clk_i)
  begin
    if (!rst_n_i)
      flag <= 1'h0;
    else if (fail_event)
      flag <= 1'h1;
    else if (wr && (avs_address_i == cfm_pkg::ADDR_FLAG) &&
             avs_writedata_i[cfm_pkg::FLAG_BIT])
      flag <= 1'h0;
  end

  // Registered interrupt and start-up indication.
  always_ff @(posedge sys_clk_i)
  begin
    if (!rst_n_i)
    begin
      irq_o         <= 1'h0;
      ost_running_o <= 1'h0;
    end
    else
    begin
      irq_o         <= flag && int_en;
      ost_running_o <= (state == SW_OST);
    end
  end

  // Read mux; unmapped offsets read as zero.
  always_comb
  begin
    next_rdata = 32'h0;
    unique case (avs_address_i)
      cfm_pkg::ADDR_CTRL:
      begin
        next_rdata[cfm_pkg::CTRL_MON_BIT] = mon_en;
        next_rdata[cfm_pkg::CTRL_IE_BIT]  = int_en;
      end
      cfm_pkg::ADDR_NEW:
        next_rdata[cfm_pkg::CFG_W-1:0] = new_cfg;
      cfm_pkg::ADDR_STATUS:
      begin
        next_rdata[cfm_pkg::CFG_W-1:0]     = cur_cfg_o;
        next_rdata[cfm_pkg::ST_FSAFE_BIT]  = failsafe_o;
        next_rdata[cfm_pkg::ST_OST_BIT]    = (state == SW_OST);
        next_rdata[cfm_pkg::ST_FAIL_BIT]   = fail_sync;
      end
      cfm_pkg::ADDR_FLAG:
        next_rdata[cfm_pkg::FLAG_BIT] = flag;
      default:
        next_rdata = 32'h0;
    endcase
  end

  // Every access is answered with exactly one wait cycle.
  always_ff @(posedge sys_clk_i)
  begin
    if (!rst_n_i)
    begin
      avs_waitrequest_o <= 1'h1;
      avs_readdata_o    <= 32'h0;
    end
    else
    begin
      avs_waitrequest_o <= !((avs_read_i || avs_write_i) &&
                             avs_waitrequest_o);
      if (avs_read_i && avs_waitrequest_o)
        avs_readdata_o <= next_rdata;
    end
  end

  default clocking cb @(posedge sys_clk_i);
  endclocking
  default disable iff (!rst_n_i);

  property p_mon_off;
    (fail_sync && !mon_en && !failsafe_o) |=> !failsafe_o;
  endproperty
  a_mon_off: assert property (p_mon_off)
    else $error("Fallback taken with monitor disabled.");

  property p_div;
    $changed(samp_clk) |-> $past(lf_rise) && ($past(div_cnt) == HALF_M1);
  endproperty
  a_div: assert property (p_div)
    else $error("Sample clock toggled off the divide count.");

  property p_latch;
    (ext_fall |=> seen) and ((samp_rise && !ext_fall) |=> !seen);
  endproperty
  a_latch: assert property (p_latch)
    else $error("Detect latch set or clear missed.");

  property p_detect;
    (samp_fall && !seen && !ext_fall) |=> fail_raw;
  endproperty
  a_detect: assert property (p_detect)
    else $error("Missing external low not reported.");

  property p_fallback;
    fail_event |=> (cur_cfg_o.osc == cfm_pkg::OSC_HFINT) && failsafe_o &&
      $stable(cur_cfg_o.div) && $stable(cur_cfg_o.internal_freq_select) && flag;
  endproperty
  a_fallback: assert property (p_fallback)
    else $error("Fallback did not select internal clock or set flag.");

  property p_irq;
    (flag && int_en) ##1 (flag && int_en) |-> irq_o;
  endproperty
  a_irq: assert property (p_irq)
    else $error("Interrupt not raised for enabled flag.");

  property p_sleep;
    (sleep_exec_i && !fail_event) |=> !failsafe_o;
  endproperty
  a_sleep: assert property (p_sleep)
    else $error("Sleep did not clear the fail-safe condition.");

  property p_ost_start;
    (new_chg && !fail_event && cfm_pkg::cfm_is_ext(wr_cfg.osc))
      |=> (state == SW_OST) && (ost_cnt == '0) ##1 ost_running_o;
  endproperty
  a_ost_start: assert property (p_ost_start)
    else $error("Start-up timer not restarted on external switch.");

  property p_ost_hold;
    ((state == SW_OST) && !ost_done && !new_chg && !fail_event)
      |=> $stable(cur_cfg_o);
  endproperty
  a_ost_hold: assert property (p_ost_hold)
    else $error("Clock changed while start-up timer ran.");

  property p_sync;
    fail_event |-> $past(fail_raw, 2);
  endproperty
  a_sync: assert property (p_sync)
    else $error("Fallback acted on an unsynchronised failure.");

  c_fail: cover property (fail_event);
  c_switch_back: cover property (ost_done && !fail_event);
  c_sleep_clear: cover property (failsafe_o && sleep_exec_i);
  c_read: cover property (avs_read_i && !avs_waitrequest_o);

endmodule

`default_nettype wire

//--- rtl/cfm_pkg.sv
// Package with constants and types for the clock fail monitor.
package cfm_pkg;

  // Register byte offsets on the Avalon-MM slave.
  localparam logic [7:0] ADDR_CTRL   = 8'h00;
  localparam logic [7:0] ADDR_NEW    = 8'h04;
  localparam logic [7:0] ADDR_STATUS = 8'h08;
  localparam logic [7:0] ADDR_FLAG   = 8'h0c;

  // Field positions.
  localparam int CTRL_MON_BIT  = 0;
  localparam int CTRL_IE_BIT   = 1;
  localparam int CFG_LSB       = 0;
  localparam int ST_FSAFE_BIT  = 12;
  localparam int ST_OST_BIT    = 13;
  localparam int ST_FAIL_BIT   = 14;
  localparam int FLAG_BIT      = 0;

  // Timing counts: low-frequency oscillator divide and start-up length.
  localparam int LF_DIV    = 64;
  localparam int OST_COUNT = 1024;

  // Oscillator selection codes.
  localparam logic [2:0] OSC_EXT_PLL = 3'h2;
  localparam logic [2:0] OSC_SOSC    = 3'h4;
  localparam logic [2:0] OSC_LFINT   = 3'h5;
  localparam logic [2:0] OSC_HFINT   = 3'h6;
  localparam logic [2:0] OSC_EXT     = 3'h7;

  // Clock configuration: frequency select, divider and source.
  typedef struct packed {
    logic [3:0] internal_freq_select;
    logic [3:0] div;
    logic [2:0] osc;
  } cfm_cfg_t;

  localparam int CFG_W = 11;

  // Reset values.
  localparam logic     RST_MON_EN = 1'h1;
  localparam logic     RST_INT_EN = 1'h0;
  localparam cfm_cfg_t RST_CFG    = '{internal_freq_select: 4'h0, div: 4'h0, osc: OSC_HFINT};

  // Any source other than the two internal oscillators is external.
  function automatic logic cfm_is_ext(input logic [2:0] osc);
    cfm_is_ext = (osc != OSC_LFINT) && (osc != OSC_HFINT);
  endfunction

endpackage

//--- sim/cfm_ext_osc_model.sv
// External oscillator model that runs or stops on command.
`timescale 1ns/1ns
`default_nettype none

module cfm_ext_osc_model
#(
  parameter int HALF = 4
)
(
  input  wire logic sys_clk_i,
  input  wire logic run_i,
  output logic      ext_clk_o
);
  int cnt = 0;

  initial ext_clk_o = 1'b1;

  // A dead crystal is modelled stuck high, so no falling edge is ever seen.
  always @(posedge sys_clk_i)
  begin
    if (!run_i)
    begin
      ext_clk_o <= 1'b1;
      cnt       <= 0;
    end
    else if (cnt == HALF - 1)
    begin
      ext_clk_o <= ~ext_clk_o;
      cnt       <= 0;
    end
    else
      cnt <= cnt + 1;
  end
endmodule

`default_nettype wire

//--- sim/clock_fail_monitor_tb_top.sv
// Self-checking testbench for the clock fail monitor.
`timescale 1ns/1ns
`default_nettype none

module clock_fail_monitor_tb_top;
  logic              sys_clk = 1'b0;
  logic              rst_n   = 1'b0;
  logic [7:0]        addr    = 8'h00;
  logic              rd_en   = 1'b0;
  logic              wr_en   = 1'b0;
  logic [31:0]       wdata   = 32'h0;
  logic              lf_osc  = 1'b0;
  logic              sleep   = 1'b0;
  logic              run     = 1'b1;
  logic [31:0]       rdata;
  logic              waitreq;
  logic              ext_clk;
  cfm_pkg::cfm_cfg_t cur_cfg;
  cfm_pkg::cfm_cfg_t tgt;
  cfm_pkg::cfm_cfg_t prev;
  logic              fs;
  logic              osc_startup_timer;
  logic              irq;
  logic [31:0]       d;
  logic [2:0]        codes [3];
  int                bad_count = 0;
  int                checked = 0;
  int                seed;

  // The short start-up count keeps each switch to a few dozen cycles.
  cfm_clock_fail_monitor #(.OST_COUNT(4)) u_cfm_clock_fail_monitor
  (
    .sys_clk_i(sys_clk), .rst_n_i(rst_n), .avs_address_i(addr),
    .avs_read_i(rd_en), .avs_write_i(wr_en), .avs_writedata_i(wdata),
    .avs_readdata_o(rdata), .avs_waitrequest_o(waitreq),
    .ext_clk_i(ext_clk), .low_freq_internal_osc_i(lf_osc),
    .sleep_exec_i(sleep), .cur_cfg_o(cur_cfg), .failsafe_o(fs),
    .ost_running_o(osc_startup_timer), .irq_o(irq)
  );

  cfm_ext_osc_model u_cfm_ext_osc_model
  (
    .sys_clk_i(sys_clk), .run_i(run), .ext_clk_o(ext_clk)
  );

  always #5 sys_clk = ~sys_clk;

  // Low-frequency oscillator: one rise every four system cycles.
  always @(posedge sys_clk)
  begin
    if ($time % 20 == 5)
      lf_osc <= ~lf_osc;
  end

  task automatic close_out();
    $display("checks %0d, mismatches %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp)
    begin
      $display("unexpected at %0t: saw %h, wanted %h", $time, seen, exp);
      bad_count++;
    end
  endtask

  // Holds the request until waitrequest is sampled low at a rising edge.
  task automatic bus(input logic w, input logic [7:0] a,
                     input logic [31:0] wd);
    int n;
    n = 0;
    @(posedge sys_clk);
    wr_en <= w;
    rd_en <= !w;
    addr  <= a;
    wdata <= wd;
    do
    begin
      @(posedge sys_clk);
      n++;
      if (n > 50)
      begin
        $display("unexpected at %0t: bus hang", $time);
        bad_count++;
        close_out();
      end
    end while (waitreq !== 1'b0);
    d = rdata;
    wr_en <= 1'b0;
    rd_en <= 1'b0;
  endtask

  // Bounded wait for failsafe (sel 0) or timer running (sel 1).
  task automatic wait_for(input int sel, input logic lvl, input int lim);
    int n;
    n = 0;
    while (((sel == 0) ? fs : osc_startup_timer) !== lvl)
    begin
      @(posedge sys_clk);
      n++;
      if (n > lim)
      begin
        $display("unexpected at %0t: wait ran out", $time);
        bad_count++;
        close_out();
      end
    end
  endtask

  // Fallback keeps frequency and divider, forces the fast internal code.
  function automatic logic [31:0] fb(input cfm_pkg::cfm_cfg_t c);
    fb = 32'({c.internal_freq_select, c.div, cfm_pkg::OSC_HFINT});
  endfunction

  task automatic stop_and_fail();
    run <= 1'b0;
    wait_for(0, 1'b1, 700);
    check(32'(cur_cfg), fb(tgt));
  endtask

  task automatic switch_ext(input logic [2:0] osc);
    tgt = '{internal_freq_select: 4'($urandom), div: tgt.div + 4'h1, osc: osc};
    bus(1'b1, cfm_pkg::ADDR_NEW, 32'(tgt));
    repeat (2) @(posedge sys_clk);
    check(32'(osc_startup_timer), 32'h1);
    check(32'(cur_cfg[2:0] == osc), 32'h0);
    wait_for(1, 1'b0, 300);
    check(32'(cur_cfg), 32'(tgt));
  endtask

  initial
  begin
    codes = '{cfm_pkg::OSC_EXT_PLL, cfm_pkg::OSC_SOSC, cfm_pkg::OSC_EXT};
    seed  = $urandom(45);
    tgt   = cfm_pkg::RST_CFG;
    repeat (20) @(posedge sys_clk);
    rst_n <= 1'b1;
    @(posedge sys_clk);
    check(32'(cur_cfg), 32'(cfm_pkg::RST_CFG));
    bus(1'b0, cfm_pkg::ADDR_CTRL, 32'h0);
    check(d, 32'h1);
    bus(1'b0, 8'h10, 32'h0);
    check(d, 32'h0);
    bus(1'b1, cfm_pkg::ADDR_CTRL, 32'h3);
    // The three named external modes in codes are each switched to, watched, and lost in turn.
    foreach (codes[i])
    begin
      run <= 1'b1;
      repeat (400) @(posedge sys_clk);
      switch_ext(codes[i]);
      repeat (300) @(posedge sys_clk);
      check(32'(fs), 32'h0);
      stop_and_fail();
      repeat (2) @(posedge sys_clk);
      check(32'(irq), 32'h1);
      bus(1'b0, cfm_pkg::ADDR_FLAG, 32'h0);
      check(d, 32'h1);
      bus(1'b1, cfm_pkg::ADDR_FLAG, 32'h1);
      repeat (3) @(posedge sys_clk);
      check(32'(irq), 32'h0);
    end
    // Switch back while the crystal is still dead: flag must come back.
    repeat (300) @(posedge sys_clk);
    check(32'(cur_cfg[2:0]), 32'(cfm_pkg::OSC_HFINT));
    // The running clock keeps the settings it had before this attempt.
    prev    = tgt;
    tgt.div = tgt.div + 4'h1;
    tgt.osc = cfm_pkg::OSC_EXT;
    bus(1'b1, cfm_pkg::ADDR_NEW, 32'(tgt));
    // The write itself clears fail-safe before the dead crystal sets it.
    @(posedge sys_clk);
    check(32'(fs), 32'h0);
    wait_for(0, 1'b1, 700);
    bus(1'b0, cfm_pkg::ADDR_FLAG, 32'h0);
    check(d, 32'h1);
    check(32'(cur_cfg), fb(prev));
    // A sleep pulse drops the fail-safe condition.
    @(posedge sys_clk);
    sleep <= 1'b1;
    @(posedge sys_clk);
    sleep <= 1'b0;
    repeat (2) @(posedge sys_clk);
    check(32'(fs), 32'h0);
    // With the monitor off a dead crystal goes unnoticed.
    bus(1'b1, cfm_pkg::ADDR_CTRL, 32'h0);
    run <= 1'b1;
    repeat (400) @(posedge sys_clk);
    switch_ext(cfm_pkg::OSC_EXT);
    run <= 1'b0;
    repeat (700) @(posedge sys_clk);
    check(32'(fs), 32'h0);
    check(32'(cur_cfg), 32'(tgt));
    close_out();
  end
endmodule

`default_nettype wire
